// File: logic/cil_console.sv
/*
 * Console indicator and switch logic: switch sampling, indicator rows,
 * address-switch capture with program-load lock, interrupt channel lamps.
 * Assumes the processor drives its events as one-cycle pulses on sys_clk;
 * switches are asynchronous pins.
 */
module cil_console #(
	parameter int WORD_W = cil_pkg::WORD_W,
	parameter int ADDR_W = cil_pkg::ADDR_W,
	parameter int CHAN_N = cil_pkg::CHAN_N
) (
	input  wire logic                      sys_clk,
	input  wire logic                      reset,
	// Console pins: one means front part down
	input  wire logic [WORD_W-1:0]         data_switch_pin,
	input  wire logic [ADDR_W-1:0]         addr_switch_pin,
	input  wire logic [3:0]                aux_switch_up_pin,
	input  wire logic                      mi_prog_disable_pin,
	// Processor events and state
	input  wire logic                      proc_run,
	input  wire logic                      halt_done,
	input  wire logic [ADDR_W-1:0]         halt_addr,
	input  wire logic [ADDR_W-1:0]         jump_target,
	input  wire logic                      instr_end,
	input  wire logic                      mem_ref_end,
	input  wire logic                      shift_step,
	input  wire logic                      stop_at_instr,
	input  wire logic                      stop_at_mem,
	input  wire logic                      stop_at_shift,
	input  wire logic                      pc_load,
	input  wire logic [ADDR_W-1:0]         pc_value,
	input  wire logic                      instr_load,
	input  wire logic [cil_pkg::HALF_W-1:0] instr_value,
	input  wire logic                      ea_step,
	input  wire logic                      ea_indirect,
	input  wire logic [cil_pkg::AC_W-1:0]  ea_index,
	input  wire logic [ADDR_W-1:0]         ea_addr,
	input  wire logic                      mem_xfer,
	input  wire logic [ADDR_W-1:0]         mem_phys_addr,
	input  wire logic [WORD_W-1:0]         mem_word,
	input  wire logic                      fm_ref,
	input  wire logic [cil_pkg::FM_W-1:0]  fm_addr,
	input  wire logic                      output_transfer_instr,
	input  wire logic [WORD_W-1:0]         prog_word,
	input  wire logic                      mem_key_run,
	input  wire logic                      single_cycle,
	input  wire logic                      addr_cond_hit,
	input  wire logic                      nxm_hit,
	input  wire logic                      parity_hit,
	input  wire logic                      condition_input_instr,
	input  wire logic [WORD_W-1:0]         condition_word,
	input  wire logic [WORD_W-1:0]         saved_pc_word,
	input  wire logic                      carry0,
	input  wire logic                      carry1,
	input  wire logic [CHAN_N-1:0]         channel_enable_in,
	input  wire logic [CHAN_N-1:0]         bus_request_in,
	input  wire logic [CHAN_N-1:0]         prog_request,
	input  wire logic [CHAN_N-1:0]         hold_start,
	input  wire logic [CHAN_N-1:0]         dismiss,
	// Lamps and switch words
	output logic [WORD_W-1:0]              data_switch_word,
	output logic [ADDR_W-1:0]              addr_switch_word,
	output logic                           fast_store_enable,
	output logic [2:0]                     aux_ctrl,
	output logic [ADDR_W-1:0]              program_counter,
	output logic [cil_pkg::HALF_W-1:0]     instruction_latch,
	output logic                           io_instr,
	output logic [cil_pkg::DEV_W-1:0]      io_device_code,
	output logic                           ind_lamp,
	output logic [cil_pkg::AC_W-1:0]       index_lamp,
	output logic [ADDR_W-1:0]              memory_addr_latch,
	output logic [WORD_W-1:0]              memory_indicator,
	output logic                           program_data_lamp,
	output logic                           indicator_locked,
	output logic [WORD_W-1:0]              parity_buffer,
	output logic                           run_lamp,
	output logic                           program_stop,
	output logic                           operator_stop,
	output logic                           memory_stop,
	output logic                           user_mode,
	output logic                           interrupt_system_on,
	output logic                           overflow_carry_condition,
	output logic [1:0]                     address_match_flags,
	output logic [CHAN_N-1:0]              channel_enable_vector,
	output logic [CHAN_N-1:0]              bus_request_vector,
	output logic [CHAN_N-1:0]              accepted_request_vector,
	output logic [CHAN_N-1:0]              held_interrupt_vector,
	output logic                           serviced_valid,
	output logic [cil_pkg::CHAN_W-1:0]     serviced_channel
);
	// ----------------------------------------------------------------
	// Pin synchronisers: three stages, change taken when 2 and 3 agree
	// ----------------------------------------------------------------
	localparam int SW_W = WORD_W + ADDR_W + 5;
	logic [SW_W-1:0] pin_in;
	logic [SW_W-1:0] s1_r, s2_r, s3_r, sw_r, sw_nxt;
	assign pin_in = {data_switch_pin, addr_switch_pin, aux_switch_up_pin,
		mi_prog_disable_pin};
	genvar gi;
	generate
		for (gi = 0; gi < SW_W; gi++) begin : g_sw
			always_comb begin
				sw_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s2_r[gi] : sw_r[gi];
			end
		end
	endgenerate
	// Stages reset to the rest position so no false change follows reset
	localparam logic [SW_W-1:0] SW_IDLE = {{(WORD_W+ADDR_W){1'b0}}, cil_pkg::AUX_NORMAL, 1'b0};
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s1_r <= SW_IDLE;
			s2_r <= SW_IDLE;
			s3_r <= SW_IDLE;
			sw_r <= SW_IDLE;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			sw_r <= sw_nxt;
		end
	end
	logic [WORD_W-1:0] dsw;
	logic [ADDR_W-1:0] asw;
	logic [3:0]        aux_up;
	logic              mi_dis;
	assign {dsw, asw, aux_up, mi_dis} = sw_r;
	// ----------------------------------------------------------------
	// Channel helpers
	// ----------------------------------------------------------------
	function automatic logic [cil_pkg::CHAN_W:0] lowest_set(input logic [CHAN_N-1:0] v);
		lowest_set = {1'b0, cil_pkg::CHAN_NONE};
		for (int i = CHAN_N - 1; i >= 0; i--) begin
			if (v[i]) begin
				lowest_set = {1'b1, 3'(i + 1)};
			end
		end
	endfunction : lowest_set
	// ----------------------------------------------------------------
	// Display and status state
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0]  pc_r, pc_nxt, mal_r, mal_nxt;
	logic [cil_pkg::HALF_W-1:0] il_r, il_nxt;
	logic               ind_r, ind_nxt;
	logic [cil_pkg::AC_W-1:0] ix_r, ix_nxt;
	logic [WORD_W-1:0]  mi_r, mi_nxt, pb_r, pb_nxt;
	logic               pd_r, pd_nxt, lock_r, lock_nxt;
	logic               pstop_r, pstop_nxt, ostop_r, ostop_nxt, mstop_r, mstop_nxt;
	logic               pion_r, pion_nxt, user_r, user_nxt, ov_r, ov_nxt;
	logic [1:0]         asm_r, asm_nxt;
	logic [CHAN_N-1:0]  act_r, act_nxt, ireq_r, ireq_nxt, req_r, req_nxt, hold_r, hold_nxt;
	logic               run_r, run_nxt;
	logic [cil_pkg::CHAN_W:0] srv_r, srv_nxt;
	logic               core_hit, fm_hit;
	always_comb begin
		core_hit  = mem_xfer && (mem_phys_addr == asw);
		fm_hit    = fm_ref && (fm_addr == asw[cil_pkg::FM_W-1:0]) &&
			(asw[ADDR_W-1:cil_pkg::FM_W] == '0);
		pc_nxt    = pc_load ? pc_value : pc_r;
		il_nxt    = instr_load ? instr_value : il_r;
		mal_nxt   = mal_r;
		ind_nxt   = ind_r;
		ix_nxt    = ix_r;
		if (ea_step) begin
			ind_nxt = ea_indirect;
			ix_nxt  = ea_index;
			mal_nxt = ea_addr;
		end
		if (instr_end) begin
			ind_nxt = 1'b0;
		end
		if (halt_done && !proc_run) begin
			mal_nxt = ADDR_W'(halt_addr + cil_pkg::ADDR_ONE);
			pc_nxt = jump_target;
		end
		pb_nxt    = mem_xfer ? mem_word : pb_r;
		mi_nxt    = mi_r;
		pd_nxt    = pd_r;
		lock_nxt  = lock_r;
		if (mi_dis || mem_key_run) begin
			lock_nxt = 1'b0;
			pd_nxt   = 1'b0;
		end
		if (proc_run && core_hit && !lock_nxt) begin
			mi_nxt = mem_word;
			pd_nxt = 1'b0;
		end
		if (output_transfer_instr && !mi_dis) begin
			mi_nxt   = prog_word;
			pd_nxt   = 1'b1;
			lock_nxt = 1'b1;
		end
		pstop_nxt = halt_done || (pstop_r && !(instr_load && run_r));
		ostop_nxt = (instr_end && stop_at_instr) || (mem_ref_end && stop_at_mem) ||
			(shift_step && stop_at_shift);
		mstop_nxt = (mem_ref_end && (single_cycle || addr_cond_hit || nxm_hit ||
			parity_hit)) || (mstop_r && !proc_run);
		pion_nxt  = condition_input_instr ? condition_word[WORD_W-1-cil_pkg::INTERRUPT_SYSTEM_ON_BIT] :
			pion_r;
		user_nxt  = saved_pc_word[WORD_W-1-cil_pkg::USER_PC_BIT];
		ov_nxt    = carry0 ^ carry1;
		asm_nxt   = {core_hit, fm_hit};
		run_nxt   = proc_run;
		act_nxt   = channel_enable_in;
		ireq_nxt  = bus_request_in;
		hold_nxt  = (hold_r & ~dismiss) | (hold_start & {CHAN_N{pion_r}});
		req_nxt   = (req_r | ((ireq_r & act_r) | prog_request)) & ~hold_nxt;
		srv_nxt   = lowest_set(hold_nxt);
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pc_r    <= cil_pkg::ADDR_ZERO;
			il_r    <= '0;
			mal_r   <= cil_pkg::ADDR_ZERO;
			ind_r   <= 1'b0;
			ix_r    <= '0;
			mi_r    <= cil_pkg::WORD_ZERO;
			pb_r    <= cil_pkg::WORD_ZERO;
			pd_r    <= 1'b0;
			lock_r  <= 1'b0;
			pstop_r <= 1'b0;
			ostop_r <= 1'b0;
			mstop_r <= 1'b0;
			pion_r  <= 1'b0;
			user_r  <= 1'b0;
			ov_r    <= 1'b0;
			asm_r   <= 2'h0;
			run_r   <= 1'b0;
			act_r   <= cil_pkg::CHAN_ZERO;
			ireq_r  <= cil_pkg::CHAN_ZERO;
			req_r   <= cil_pkg::CHAN_ZERO;
			hold_r  <= cil_pkg::CHAN_ZERO;
			srv_r   <= '0;
		end else begin
			pc_r    <= pc_nxt;
			il_r    <= il_nxt;
			mal_r   <= mal_nxt;
			ind_r   <= ind_nxt;
			ix_r    <= ix_nxt;
			mi_r    <= mi_nxt;
			pb_r    <= pb_nxt;
			pd_r    <= pd_nxt;
			lock_r  <= lock_nxt;
			pstop_r <= pstop_nxt;
			ostop_r <= ostop_nxt;
			mstop_r <= mstop_nxt;
			pion_r  <= pion_nxt;
			user_r  <= user_nxt;
			ov_r    <= ov_nxt;
			asm_r   <= asm_nxt;
			run_r   <= run_nxt;
			act_r   <= act_nxt;
			ireq_r  <= ireq_nxt;
			req_r   <= req_nxt;
			hold_r  <= hold_nxt;
			srv_r   <= srv_nxt;
		end
	end
	// ----------------------------------------------------------------
	// Output registers derived from the instruction latch and the auxiliary switches
	// ----------------------------------------------------------------
	logic io_r, io_nxt;
	logic [cil_pkg::DEV_W-1:0] dev_r, dev_nxt;
	logic [2:0] auxc_r, auxc_nxt;
	always_comb begin
		io_nxt  = (il_nxt[cil_pkg::HALF_W-1 -: cil_pkg::IO_OPC_TOP] == cil_pkg::IO_TOP3);
		dev_nxt = {il_nxt[cil_pkg::HALF_W-1-cil_pkg::IO_OPC_TOP -: cil_pkg::DEV_W-1],
			il_nxt[cil_pkg::HALF_W-1-cil_pkg::OPC_W]};
		auxc_nxt = ~aux_up[3:1];
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			io_r   <= 1'b0;
			dev_r  <= '0;
			auxc_r <= '0;
		end else begin
			io_r   <= io_nxt;
			dev_r  <= dev_nxt;
			auxc_r <= auxc_nxt;
		end
	end
	// Lamps come straight from the flip-flops above
	assign data_switch_word  = dsw;
	assign addr_switch_word  = asw;
	assign fast_store_enable = aux_up[0];
	assign aux_ctrl          = auxc_r;
	assign program_counter   = pc_r;
	assign instruction_latch = il_r;
	assign io_instr          = io_r;
	assign io_device_code    = dev_r;
	assign ind_lamp          = ind_r;
	assign index_lamp        = ix_r;
	assign memory_addr_latch = mal_r;
	assign memory_indicator  = mi_r;
	assign program_data_lamp = pd_r;
	assign indicator_locked  = lock_r;
	assign parity_buffer     = pb_r;
	assign run_lamp          = run_r;
	assign program_stop      = pstop_r;
	assign operator_stop     = ostop_r;
	assign memory_stop       = mstop_r;
	assign user_mode         = user_r;
	assign interrupt_system_on = pion_r;
	assign overflow_carry_condition = ov_r;
	assign address_match_flags = asm_r;
	assign channel_enable_vector = act_r;
	assign bus_request_vector = ireq_r;
	assign accepted_request_vector = req_r;
	assign held_interrupt_vector = hold_r;
	assign serviced_valid    = srv_r[cil_pkg::CHAN_W];
	assign serviced_channel  = srv_r[cil_pkg::CHAN_W-1:0];
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_halt_seen;
		halt_done && !proc_run;
	endsequence
	property p_ovf;
		@(posedge sys_clk) disable iff (reset) 1 |=> (ov_r == $past(carry0 ^ carry1));
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow wrong");
	property p_pb;
		@(posedge sys_clk) disable iff (reset) mem_xfer |=> (pb_r == $past(mem_word));
	endproperty
	a_pb: assert property (p_pb) else $error("parity buffer missed");
	property p_req_blk;
		@(posedge sys_clk) disable iff (reset) 1 |-> ((req_r & hold_r) == '0);
	endproperty
	a_req_blk: assert property (p_req_blk) else $error("request with hold");
	property p_srv;
		@(posedge sys_clk) disable iff (reset) (hold_r == '0) |-> !serviced_valid;
	endproperty
	a_srv: assert property (p_srv) else $error("serviced without hold");
	property p_halt;
		@(posedge sys_clk) disable iff (reset) s_halt_seen |=>
			(mal_r == ADDR_W'($past(halt_addr) + cil_pkg::ADDR_ONE)) &&
			(pc_r == $past(jump_target));
	endproperty
	a_halt: assert property (p_halt) else $error("halt address wrong");
	property p_ind;
		@(posedge sys_clk) disable iff (reset) instr_end |=> !ind_r;
	endproperty
	a_ind: assert property (p_ind) else $error("indirect not cleared");
	property p_lock;
		@(posedge sys_clk) disable iff (reset)
			(lock_r && !mi_dis && !mem_key_run && !output_transfer_instr) |=> $stable(mi_r);
	endproperty
	a_lock: assert property (p_lock) else $error("locked indicators changed");
	property p_mstop;
		@(posedge sys_clk) disable iff (reset) (mem_ref_end && parity_hit) |=> memory_stop;
	endproperty
	a_mstop: assert property (p_mstop) else $error("memory stop missing");
	property p_prog;
		@(posedge sys_clk) disable iff (reset)
			(output_transfer_instr && !mi_dis) |=> (program_data_lamp && mi_r == $past(prog_word));
	endproperty
	a_prog: assert property (p_prog) else $error("program load missed");
endmodule : cil_console

// File: logic/cil_pkg.sv
/*
 * Constants for the console indicator and switch logic.
 * Assumes one processor clock and an active-high asynchronous reset.
 */
package cil_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int WORD_W = 36;
	localparam int ADDR_W = 18;
	localparam int CHAN_N = 7;
	localparam int CHAN_W = 3;
	localparam int HALF_W = 18;
	localparam int OPC_W  = 9;
	localparam int AC_W   = 4;
	localparam int DEV_W  = 7;
	localparam int FM_W   = 4;
	// ----------------------------------------------------------------
	// Field positions (bit 0 is the leftmost, as printed)
	// ----------------------------------------------------------------
	localparam int IO_OPC_TOP   = 3;
	localparam int INTERRUPT_SYSTEM_ON_BIT    = 28;
	localparam int USER_PC_BIT  = 5;
	// ----------------------------------------------------------------
	// Codes and reset values
	// ----------------------------------------------------------------
	localparam logic [CHAN_W-1:0] CHAN_NONE = 3'h0;
	localparam logic [2:0]        IO_TOP3   = 3'h7;
	localparam logic [3:0]        AUX_NORMAL = 4'hF;
	localparam logic [WORD_W-1:0] WORD_ZERO = 36'h000000000;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h00000;
	localparam logic [ADDR_W-1:0] ADDR_ONE  = 18'h00001;
	localparam logic [CHAN_N-1:0] CHAN_ZERO = 7'h00;
	localparam logic [1:0]        SYNC_ZERO = 2'h0;
endpackage : cil_pkg

// File: verif/cil_operator.sv
/*
 * Operator at the console: holds the data, address and auxiliary switches
 * and the indicator program-disable switch.
 * Assumes the bench calls set_switches just after a rising clock edge.
 */
module cil_operator (
	output logic [35:0] data_switch_pin,
	output logic [17:0] addr_switch_pin,
	output logic [3:0]  aux_switch_up_pin,
	output logic        mi_prog_disable_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// Switch positions
	// ----------------------------------------------------------------
	// Auxiliary switches rest with the upper part in
	initial begin
		data_switch_pin = 36'h000000000;
		addr_switch_pin = 18'h00000;
		aux_switch_up_pin = 4'hF;
		mi_prog_disable_pin = 1'b0;
	end
	task set_switches(input logic [35:0] d, input logic [17:0] a, input logic [3:0] aux,
		input logic dis);
		data_switch_pin <= d;
		addr_switch_pin <= a;
		aux_switch_up_pin <= aux;
		mi_prog_disable_pin <= dis;
	endtask : set_switches
endmodule : cil_operator

// File: verif/tb_cil_console.sv
/*
 * Self-checking bench for the console indicator logic.
 * Assumes processor events are one-cycle pulses and outputs answer one cycle later.
 */
module tb_cil_console;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, reset, proc_run, halt_done, instr_end, mem_ref_end, shift_step;
	logic stop_at_instr, stop_at_mem, stop_at_shift, pc_load, instr_load, ea_step;
	logic ea_indirect, mem_xfer, fm_ref, output_transfer_instr, mem_key_run, single_cycle;
	logic addr_cond_hit, nxm_hit, parity_hit, condition_input_instr, carry0, carry1;
	logic [17:0] halt_addr, jump_target, pc_value, instr_value, ea_addr, mem_phys_addr;
	logic [3:0]  ea_index, fm_addr, aux_switch_up_pin, index_lamp;
	logic [35:0] mem_word, prog_word, condition_word, saved_pc_word, data_switch_pin;
	logic [6:0]  channel_enable_in, bus_request_in, prog_request, hold_start, dismiss;
	logic [17:0] addr_switch_pin, addr_switch_word, program_counter, instruction_latch;
	logic [17:0] memory_addr_latch;
	logic [35:0] data_switch_word, memory_indicator, parity_buffer;
	logic        mi_prog_disable_pin, fast_store_enable, io_instr, ind_lamp, run_lamp;
	logic        program_data_lamp, indicator_locked, program_stop, operator_stop;
	logic        memory_stop, user_mode, interrupt_system_on, overflow_carry_condition;
	logic        serviced_valid;
	logic [2:0]  aux_ctrl, serviced_channel;
	logic [1:0]  address_match_flags;
	logic [6:0]  io_device_code, channel_enable_vector, bus_request_vector;
	logic [6:0]  accepted_request_vector, held_interrupt_vector;
	int          errors, n_compared, cycles, k;

	cil_console i_cil_console (.sys_clk, .reset, .data_switch_pin, .addr_switch_pin,
		.aux_switch_up_pin, .mi_prog_disable_pin, .proc_run, .halt_done, .halt_addr,
		.jump_target, .instr_end, .mem_ref_end, .shift_step, .stop_at_instr, .stop_at_mem,
		.stop_at_shift, .pc_load, .pc_value, .instr_load, .instr_value, .ea_step,
		.ea_indirect, .ea_index, .ea_addr, .mem_xfer, .mem_phys_addr, .mem_word, .fm_ref,
		.fm_addr, .output_transfer_instr, .prog_word, .mem_key_run, .single_cycle,
		.addr_cond_hit, .nxm_hit, .parity_hit, .condition_input_instr, .condition_word,
		.saved_pc_word, .carry0, .carry1, .channel_enable_in, .bus_request_in,
		.prog_request, .hold_start, .dismiss, .data_switch_word, .addr_switch_word,
		.fast_store_enable, .aux_ctrl, .program_counter, .instruction_latch, .io_instr,
		.io_device_code, .ind_lamp, .index_lamp, .memory_addr_latch, .memory_indicator,
		.program_data_lamp, .indicator_locked, .parity_buffer, .run_lamp, .program_stop,
		.operator_stop, .memory_stop, .user_mode, .interrupt_system_on,
		.overflow_carry_condition, .address_match_flags, .channel_enable_vector,
		.bus_request_vector, .accepted_request_vector, .held_interrupt_vector,
		.serviced_valid, .serviced_channel);
	cil_operator i_cil_operator (.data_switch_pin, .addr_switch_pin, .aux_switch_up_pin,
		.mi_prog_disable_pin);

	// ----------------------------------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			wrap_up();
		end
	end
	task check(input logic [35:0] seen, input logic [35:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : settle
	task wrap_up;
		$display("compared=%0d mismatches=%0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	task xfer(input logic [17:0] a, input logic [35:0] w);
		@(posedge sys_clk);
		mem_xfer <= 1'b1;
		mem_phys_addr <= a;
		mem_word <= w;
		@(posedge sys_clk);
		mem_xfer <= 1'b0;
		#1;
	endtask : xfer
	task prog_load(input logic [35:0] w);
		@(posedge sys_clk);
		output_transfer_instr <= 1'b1;
		prog_word <= w;
		@(posedge sys_clk);
		output_transfer_instr <= 1'b0;
		#1;
	endtask : prog_load

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{proc_run, halt_done, instr_end, mem_ref_end, shift_step, stop_at_instr, stop_at_mem,
			stop_at_shift, pc_load, instr_load, ea_step, ea_indirect, mem_xfer, fm_ref,
			output_transfer_instr, mem_key_run, single_cycle, addr_cond_hit, nxm_hit,
			parity_hit, condition_input_instr, carry0, carry1, halt_addr, jump_target,
			pc_value, instr_value, ea_addr, mem_phys_addr, ea_index, fm_addr, mem_word,
			prog_word, condition_word, saved_pc_word, channel_enable_in, bus_request_in,
			prog_request, hold_start, dismiss} = '0;
		{errors, n_compared, cycles} = '0;
		reset = 1'b1;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		settle(1);
		check(fast_store_enable, 1'b1);
		check(aux_ctrl, 3'h0);
		check({serviced_valid, serviced_channel}, 4'h0);
		$display("test reset done");
		@(posedge sys_clk);
		i_cil_operator.set_switches(36'h8000000C3, 18'h20005, 4'h0, 1'b0);
		settle(6);
		check(data_switch_word, 36'h8000000C3);
		check(addr_switch_word, 18'h20005);
		check({fast_store_enable, aux_ctrl}, 4'h7);
		i_cil_operator.set_switches(36'h000000000, 18'h00005, 4'hF, 1'b0);
		settle(6);
		$display("test switches done");
		@(posedge sys_clk);
		{proc_run, pc_load, instr_load} <= 3'h7;
		pc_value <= 18'h01234;
		instr_value <= 18'h3D300;
		@(posedge sys_clk);
		{pc_load, instr_load, ea_step, ea_indirect} <= 4'h3;
		ea_index <= 4'hA;
		ea_addr <= 18'h2ABCD;
		#1;
		check({program_counter, instruction_latch}, {18'h01234, 18'h3D300});
		check({io_instr, io_device_code, run_lamp}, {1'b1, 7'h53, 1'b1});
		@(posedge sys_clk);
		{ea_step, ea_indirect, instr_end} <= 3'h1;
		#1;
		check({ind_lamp, index_lamp, memory_addr_latch}, {5'h1A, 18'h2ABCD});
		@(posedge sys_clk);
		instr_end <= 1'b0;
		#1;
		check(ind_lamp, 1'b0);
		for (k = 0; k < 6; k++) begin
			@(posedge sys_clk);
			{stop_at_instr, stop_at_mem, stop_at_shift} <= (k < 3) ? 3'h0 : 3'h4 >> (k - 3);
			{instr_end, mem_ref_end, shift_step} <= 3'h4 >> (k % 3);
			@(posedge sys_clk);
			{instr_end, mem_ref_end, shift_step} <= 3'h0;
			#1;
			check(operator_stop, k >= 3);
			settle(1);
			check(operator_stop, 1'b0);
		end
		$display("test lamps done");
		xfer(18'h00005, 36'h123456789);
		check({memory_indicator, parity_buffer}, {2{36'h123456789}});
		check({address_match_flags[1], program_data_lamp}, 2'h2);
		xfer(18'h00006, 36'hFEDCBA987);
		check({memory_indicator, parity_buffer}, {36'h123456789, 36'hFEDCBA987});
		check(address_match_flags[1], 1'b0);
		@(posedge sys_clk);
		{fm_ref, fm_addr, proc_run} <= 6'h2A;
		@(posedge sys_clk);
		fm_ref <= 1'b0;
		#1;
		check(address_match_flags[0], 1'b1);
		xfer(18'h00005, 36'h0000000AA);
		check({memory_indicator, parity_buffer}, {36'h123456789, 36'h0000000AA});
		$display("test capture done");
		@(posedge sys_clk);
		proc_run <= 1'b1;
		prog_load(36'h0F0F0F0F0);
		check({memory_indicator, program_data_lamp, indicator_locked}, {36'h0F0F0F0F0, 2'h3});
		xfer(18'h00005, 36'h555555555);
		check(memory_indicator, 36'h0F0F0F0F0);
		@(posedge sys_clk);
		mem_key_run <= 1'b1;
		@(posedge sys_clk);
		mem_key_run <= 1'b0;
		settle(1);
		check(indicator_locked, 1'b0);
		xfer(18'h00005, 36'h555555555);
		check({memory_indicator, program_data_lamp}, {36'h555555555, 1'b0});
		i_cil_operator.set_switches(36'h000000000, 18'h00005, 4'hF, 1'b1);
		settle(6);
		prog_load(36'h0F0F0F0F0);
		check({memory_indicator, indicator_locked}, {36'h555555555, 1'b0});
		i_cil_operator.set_switches(36'h000000000, 18'h00005, 4'hF, 1'b0);
		settle(6);
		$display("test program load done");
		@(posedge sys_clk);
		{proc_run, halt_done} <= 2'h1;
		halt_addr <= 18'h1FFFF;
		jump_target <= 18'h00777;
		@(posedge sys_clk);
		halt_done <= 1'b0;
		#1;
		check({memory_addr_latch, program_counter, program_stop}, {18'h20000, 18'h00777, 1'b1});
		for (k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			proc_run <= 1'b1;
			settle(3);
			check(memory_stop, 1'b0);
			@(posedge sys_clk);
			{mem_ref_end, single_cycle, addr_cond_hit, nxm_hit, parity_hit} <= 5'h10 | (5'h08 >> k);
			proc_run <= 1'b0;
			@(posedge sys_clk);
			{mem_ref_end, single_cycle, addr_cond_hit, nxm_hit, parity_hit} <= 5'h00;
			#1;
			check(memory_stop, 1'b1);
		end
		for (k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			{carry0, carry1} <= k[1:0];
			saved_pc_word <= k[0] ? 36'h040000000 : 36'hFBFFFFFFF;
			condition_word <= k[0] ? 36'h000000080 : 36'hFFFFFFF7F;
			condition_input_instr <= 1'b1;
			@(posedge sys_clk);
			condition_input_instr <= 1'b0;
			settle(1);
			check(overflow_carry_condition, k[0] ^ k[1]);
			check({user_mode, interrupt_system_on}, {2{k[0]}});
		end
		$display("test status done");
		@(posedge sys_clk);
		channel_enable_in <= 7'h14;
		bus_request_in <= 7'h7E;
		prog_request <= 7'h01;
		settle(3);
		check({channel_enable_vector, bus_request_vector}, {7'h14, 7'h7E});
		check(accepted_request_vector, 7'h15);
		@(posedge sys_clk);
		hold_start <= 7'h15;
		@(posedge sys_clk);
		hold_start <= 7'h00;
		settle(3);
		check({held_interrupt_vector, accepted_request_vector}, {7'h15, 7'h00});
		check({serviced_valid, serviced_channel}, 4'h9);
		for (k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			dismiss <= k ? 7'h14 : 7'h01;
			@(posedge sys_clk);
			dismiss <= 7'h00;
			settle(3);
			check(held_interrupt_vector, k ? 7'h00 : 7'h14);
			check({serviced_valid, serviced_channel}, k ? 4'h0 : 4'hB);
			check(accepted_request_vector, k ? 7'h15 : 7'h01);
		end
		$display("test channels done");
		@(posedge sys_clk);
		proc_run <= 1'b1;
		prog_load(36'h0F0F0F0F0);
		@(posedge sys_clk);
		reset <= 1'b1;
		settle(2);
		check({indicator_locked, program_data_lamp}, 2'h0);
		@(posedge sys_clk);
		reset <= 1'b0;
		settle(2);
		check({fast_store_enable, aux_ctrl}, 4'h8);
		$display("test reset unlock done");
		wrap_up();
	end
endmodule : tb_cil_console
